// ### rtl/metering_map.svh
// Offsets, field positions, reset values and timing counts of the metering support block.
`ifndef METERING_MAP_SVH
`define METERING_MAP_SVH

// ----------------------------------------------------------------------------
// Configuration byte
// ----------------------------------------------------------------------------
`define ACC_CFG_ADDR 16'h2001
`define ACC_CFG_RESET 8'h00
`define FIRST_STAGE_MSB 7
`define FIRST_STAGE_LSB 6
`define SECOND_STAGE_MSB 5
`define SECOND_STAGE_LSB 0

// ----------------------------------------------------------------------------
// Realtime monitor
// ----------------------------------------------------------------------------
`define MON_WORDS 4
`define MON_WORD_CYCLES 35
`define MON_DATA_BITS 32
`define TEST_CLK_DIV 4

// ----------------------------------------------------------------------------
// Pulse generators
// ----------------------------------------------------------------------------
`define PULSE_FIFO_DEPTH 8
`define SPACING_UNIT 4
`define WIDTH_CHECK_OFF 8'hff
`define FIR_CLK_DIV 10
`define OPT_SRC_REAL 2'h1
`define OPT_SRC_REACTIVE 2'h2

// ----------------------------------------------------------------------------
// Data RAM time slots
// ----------------------------------------------------------------------------
`define RAM_WORDS 1024
`define REF_CLK_NS 20
`define RAM_SLOT_NS 100
`define RAM_SLOT_CYCLES (`RAM_SLOT_NS / `REF_CLK_NS)
`define SLOT_MPU_A 3'h0
`define SLOT_MPU_B 3'h1
`define SLOT_CE 3'h2
`define SLOT_SPI 3'h3
`define SLOT_LAST 3'h4

`endif

// ### rtl/metering_pkg.sv
// Types shared by the metering support block.
package metering_pkg;

  typedef enum logic [1:0] {
    MON_IDLE = 2'h0,
    MON_READ = 2'h1,
    MON_DRAIN = 2'h3
  } mon_state_t;

  typedef logic [9:0] word_addr_t;
  typedef logic [31:0] word_t;

endpackage : metering_pkg

// ### rtl/ram_port_if.sv
// Single access port of the shared data RAM.
`timescale 1ns/100ps
`default_nettype none

interface ram_port_if;
  metering_pkg::word_addr_t addr;
  logic we;
  metering_pkg::word_t wdata;
  metering_pkg::word_t rdata;

  modport master (output addr, output we, output wdata, input rdata);
  modport memory (input addr, input we, input wdata, output rdata);
endinterface : ram_port_if

`default_nettype wire

// ### rtl/data_ram.sv
// Shared 1024 x 32 data RAM with registered read data.
`timescale 1ns/100ps
`default_nettype none
`include "metering_map.svh"

module data_ram (
  input wire logic ref_clk,      // System clock.
  ram_port_if.memory port        // One access per cycle.
);

  metering_pkg::word_t mem [0:`RAM_WORDS-1];
  metering_pkg::word_t rdata_q;

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    rdata_q <= mem[port.addr];
  end

  assign port.rdata = rdata_q;

endmodule : data_ram

`default_nettype wire

// ### rtl/metering_engine_support.sv
// Support hardware around the metering compute engine: monitor, pulses, accumulation, RAM sharing.
// Operation
// - Four selected RAM words are shifted out on the test output each pass.
// - The monitor starts a pass only if its enable is set at frame start.
// - Each monitored word takes 35 test clocks, flag bit first.
// - The monitor output stays low when not shifting.
// - Polarity invert set makes all pulses active high, else active low.
// - Auxiliary pulses drive general io eight and nine, updated once per pass.
// - Real and reactive sign bits go through an 8-entry FIFO, emitted at spacing.
// - The pulse FIFO is emptied at each frame start.
// - Spacing sets first delay and gap; one count is 4 filter clocks.
// - Spacing zero bypasses the FIFO; outputs follow exports at once.
// - Active pulse limited to twice the limit plus one updates; 255 disables.
// - Real pulse on io six, reactive on io seven, either to optical out.
// - A completed accumulation raises the accumulation done interrupt.
// - Each frame end raises the frame done interrupt.
// - In alternate frames the engine fills the samples not taken.
// - The RAM is shared in slots: two processor, one engine, one serial access.
// - Processor byte writes become a two-access read-modify-write.
// - Frame sync rising edge starts each pass with the monitor readout.
`timescale 1ns/100ps
`default_nettype none
`include "metering_map.svh"

module metering_engine_support (
  input wire logic ref_clk,                  // 50 MHz system clock.
  input wire logic rst_n,                    // Synchronous reset, active low.
  input wire logic [15:0] io_addr,           // Configuration byte address.
  input wire logic io_we,                    // Configuration write strobe.
  input wire logic [7:0] io_wdata,           // Configuration write data.
  output logic [7:0] io_rdata,               // Configuration read data.
  input wire logic [2:0] equation_select,    // Meter equation choice.
  output logic [2:0] equation_assist,        // Equation choice as applied to the engine.
  input wire logic monitor_enable,           // Realtime monitor enable.
  input wire logic [39:0] monitor_addr,      // Four monitored word addresses.
  output logic test_mux_output,              // Serial monitor output.
  output logic test_clock,                   // Monitor shift clock.
  input wire logic frame_sync,               // High between multiplexer frames.
  input wire logic alternate_frame,          // Current frame is an alternate frame.
  output logic fill_missing_samples,         // Engine must fill untaken samples.
  output logic frame_done_irq,               // Frame end pulse.
  output logic accumulation_done_irq,        // Accumulation end pulse.
  input wire logic pulse_export_valid,       // Engine exports pulse sign bits.
  output logic pulse_export_ready,           // Pulse FIFO accepts an export.
  input wire logic real_sign,                // Exported real energy sign bit.
  input wire logic reactive_sign,            // Exported reactive sign bit.
  input wire logic aux_x_level,              // Engine level for the x pulse.
  input wire logic aux_y_level,              // Engine level for the y pulse.
  input wire logic pulse_polarity_invert,    // Pulses active high when set.
  input wire logic [7:0] pulse_spacing,      // Pulse update spacing.
  input wire logic [7:0] pulse_width_limit,  // Active pulse width limit.
  input wire logic [1:0] optical_transmit_source, // Optical output source.
  output logic general_io_six,               // Real energy pulse.
  output logic general_io_seven,             // Reactive pulse.
  output logic general_io_eight,             // Auxiliary x pulse.
  output logic general_io_nine,              // Auxiliary y pulse.
  output logic optical_transmit,             // Optical pulse output.
  input wire logic mpu_req,                  // Processor byte access request.
  input wire logic mpu_we,                   // Processor write.
  input wire logic [11:0] mpu_addr,          // Processor byte address.
  input wire logic [7:0] mpu_wdata,          // Processor write byte.
  output logic [7:0] mpu_rdata,              // Processor read byte.
  output logic mpu_ack,                      // Processor access done.
  input wire logic ce_req,                   // Engine access request.
  input wire logic ce_we,                    // Engine write.
  input wire logic [9:0] ce_addr,            // Engine word address.
  input wire logic [31:0] ce_wdata,          // Engine write word.
  output logic [31:0] ce_rdata,              // Engine read word.
  output logic ce_ack,                       // Engine access done.
  input wire logic spi_req,                  // Serial port access request.
  input wire logic spi_we,                   // Serial port write.
  input wire logic [9:0] spi_addr,           // Serial port word address.
  input wire logic [31:0] spi_wdata,         // Serial port write word.
  output logic [31:0] spi_rdata,             // Serial port read word.
  output logic spi_ack                       // Serial port access done.
);

  // --------------------------------------------------------------------------
  // Frame timing and rate enables
  // --------------------------------------------------------------------------
  logic fsync_q;
  logic [3:0] fir_div_q;
  logic [2:0] tst_div_q;
  logic test_clock_q;
  wire frame_start = frame_sync & ~fsync_q;
  wire fir_tick = (fir_div_q == 4'(`FIR_CLK_DIV - 1));
  wire tst_tick = (tst_div_q == 3'(`TEST_CLK_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fsync_q <= 1'b0;
      fir_div_q <= 4'h0;
      tst_div_q <= 3'h0;
      test_clock_q <= 1'b0;
    end else begin
      fsync_q <= frame_sync;
      fir_div_q <= fir_tick ? 4'h0 : fir_div_q + 4'h1;
      tst_div_q <= tst_tick ? 3'h0 : tst_div_q + 3'h1;
      test_clock_q <= (tst_div_q < 3'(`TEST_CLK_DIV / 2)) ? 1'b0 : 1'b1;
    end
  end
  assign test_clock = test_clock_q;

  // --------------------------------------------------------------------------
  // Configuration byte, equation and frame events
  // --------------------------------------------------------------------------
  logic [7:0] acc_cfg_q;
  logic [7:0] io_rdata_q;
  logic [2:0] equ_q;
  logic alt_q;
  logic frame_irq_q;
  logic acc_irq_q;
  logic [1:0] stage1_q;
  logic [5:0] stage2_q;
  wire cfg_hit = (io_addr == `ACC_CFG_ADDR);
  wire [1:0] stage1_len = acc_cfg_q[`FIRST_STAGE_MSB:`FIRST_STAGE_LSB];
  wire [5:0] stage2_len = acc_cfg_q[`SECOND_STAGE_MSB:`SECOND_STAGE_LSB];
  wire stage1_end = (stage1_q + 2'h1 >= stage1_len) | (stage1_len == 2'h0);
  wire stage2_end = (stage2_q + 6'h1 >= stage2_len) | (stage2_len == 6'h0);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_cfg_q <= `ACC_CFG_RESET;
      io_rdata_q <= 8'h00;
      equ_q <= 3'h0;
      alt_q <= 1'b0;
      frame_irq_q <= 1'b0;
      acc_irq_q <= 1'b0;
      stage1_q <= 2'h0;
      stage2_q <= 6'h0;
    end else begin
      if (io_we && cfg_hit) begin
        acc_cfg_q <= io_wdata;
      end
      io_rdata_q <= cfg_hit ? acc_cfg_q : 8'h00;
      equ_q <= equation_select;
      frame_irq_q <= frame_start;
      acc_irq_q <= 1'b0;
      if (frame_start) begin
        alt_q <= alternate_frame;
        if (stage1_end) begin
          stage1_q <= 2'h0;
          if (stage2_end) begin
            stage2_q <= 6'h0;
            acc_irq_q <= 1'b1;
          end else begin
            stage2_q <= stage2_q + 6'h1;
          end
        end else begin
          stage1_q <= stage1_q + 2'h1;
        end
      end
    end
  end
  assign io_rdata = io_rdata_q;
  assign equation_assist = equ_q;
  assign fill_missing_samples = alt_q;
  assign frame_done_irq = frame_irq_q;
  assign accumulation_done_irq = acc_irq_q;

  // --------------------------------------------------------------------------
  // Data RAM slot sharing
  // --------------------------------------------------------------------------
  ram_port_if ram ();
  data_ram u_ram (
    .ref_clk(ref_clk),
    .port(ram.memory)
  );

  logic [2:0] slot_q;
  logic mpu_busy_q;
  logic mpu_ack_q;
  logic [7:0] mpu_rdata_q;
  logic ce_pend_q;
  logic ce_ack_q;
  logic [31:0] ce_rdata_q;
  logic spi_pend_q;
  logic spi_ack_q;
  logic [31:0] spi_rdata_q;
  logic mon_pend_q;
  logic mon_issue;
  metering_pkg::word_addr_t mon_rd_addr;
  wire in_mpu_a = (slot_q == `SLOT_MPU_A);
  wire in_mpu_b = (slot_q == `SLOT_MPU_B);
  wire in_ce = (slot_q == `SLOT_CE);
  wire in_spi = (slot_q == `SLOT_SPI);
  wire [1:0] byte_sel = mpu_addr[1:0];
  wire mpu_go = in_mpu_a & mpu_req & ~mpu_ack_q;
  wire ce_go = in_ce & ~mon_issue & ce_req & ~ce_ack_q;
  wire spi_go = in_spi & spi_req & ~spi_ack_q;
  wire [31:0] merged = {byte_sel == 2'h3 ? mpu_wdata : ram.rdata[31:24],
                        byte_sel == 2'h2 ? mpu_wdata : ram.rdata[23:16],
                        byte_sel == 2'h1 ? mpu_wdata : ram.rdata[15:8],
                        byte_sel == 2'h0 ? mpu_wdata : ram.rdata[7:0]};
  wire [7:0] read_byte = ram.rdata[8*byte_sel +: 8];

  assign ram.addr = in_mpu_a | in_mpu_b ? mpu_addr[11:2] :
                    in_ce ? (mon_issue ? mon_rd_addr : ce_addr) : spi_addr;
  assign ram.we = (in_mpu_b & mpu_busy_q & mpu_we) | (ce_go & ce_we) | (spi_go & spi_we);
  assign ram.wdata = in_mpu_b ? merged : in_ce ? ce_wdata : spi_wdata;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slot_q <= 3'h0;
      mpu_busy_q <= 1'b0;
      mpu_ack_q <= 1'b0;
      mpu_rdata_q <= 8'h00;
      ce_pend_q <= 1'b0;
      ce_ack_q <= 1'b0;
      ce_rdata_q <= 32'h0;
      spi_pend_q <= 1'b0;
      spi_ack_q <= 1'b0;
      spi_rdata_q <= 32'h0;
    end else begin
      slot_q <= (slot_q == 3'(`RAM_SLOT_CYCLES - 1)) ? 3'h0 : slot_q + 3'h1;
      mpu_busy_q <= mpu_go;
      mpu_ack_q <= in_mpu_b & mpu_busy_q;
      if (in_mpu_b && mpu_busy_q) begin
        mpu_rdata_q <= read_byte;
      end
      ce_pend_q <= ce_go;
      ce_ack_q <= ce_pend_q;
      if (ce_pend_q) begin
        ce_rdata_q <= ram.rdata;
      end
      spi_pend_q <= spi_go;
      spi_ack_q <= spi_pend_q;
      if (spi_pend_q) begin
        spi_rdata_q <= ram.rdata;
      end
    end
  end
  assign mpu_ack = mpu_ack_q;
  assign mpu_rdata = mpu_rdata_q;
  assign ce_ack = ce_ack_q;
  assign ce_rdata = ce_rdata_q;
  assign spi_ack = spi_ack_q;
  assign spi_rdata = spi_rdata_q;

  // --------------------------------------------------------------------------
  // Realtime monitor: reader, two-entry buffer, shifter
  // --------------------------------------------------------------------------
  metering_pkg::mon_state_t mon_state_q;
  logic [1:0] rd_idx_q;
  logic [2:0] words_left_q;
  logic [1:0] buf_cnt_q;
  logic buf_head_q;
  logic [31:0] buf_q [0:1];
  logic shifting_q;
  logic [5:0] bit_cnt_q;
  logic [34:0] shreg_q;
  wire buf_in_ready = ({1'b0, buf_cnt_q} + {2'h0, mon_pend_q}) < 3'h2;
  wire buf_out_valid = (buf_cnt_q != 2'h0);
  wire buf_out_ready = ~shifting_q;
  wire buf_pop = buf_out_valid & buf_out_ready;
  wire buf_push = mon_pend_q;
  wire [1:0] buf_tail = 2'(buf_head_q) + buf_cnt_q;
  assign mon_issue = (mon_state_q == metering_pkg::MON_READ) & in_ce & buf_in_ready;
  assign mon_rd_addr = monitor_addr[10*rd_idx_q +: 10];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mon_state_q <= metering_pkg::MON_IDLE;
      rd_idx_q <= 2'h0;
      words_left_q <= 3'h0;
      mon_pend_q <= 1'b0;
      buf_cnt_q <= 2'h0;
      buf_head_q <= 1'b0;
      buf_q[0] <= 32'h0;
      buf_q[1] <= 32'h0;
    end else begin
      mon_pend_q <= mon_issue;
      unique case (mon_state_q)
        metering_pkg::MON_IDLE: begin
          if (frame_start && monitor_enable) begin
            mon_state_q <= metering_pkg::MON_READ;
            rd_idx_q <= 2'h0;
            words_left_q <= 3'(`MON_WORDS);
          end
        end
        metering_pkg::MON_READ: begin
          if (mon_issue) begin
            rd_idx_q <= rd_idx_q + 2'h1;
            if (rd_idx_q == 2'(`MON_WORDS - 1)) begin
              mon_state_q <= metering_pkg::MON_DRAIN;
            end
          end
        end
        metering_pkg::MON_DRAIN: begin
          if (words_left_q == 3'h0 && !shifting_q) begin
            mon_state_q <= metering_pkg::MON_IDLE;
          end
        end
        default: begin
          mon_state_q <= metering_pkg::MON_IDLE;
        end
      endcase
      if (buf_pop) begin
        words_left_q <= words_left_q - 3'h1;
        buf_head_q <= ~buf_head_q;
      end
      if (buf_push) begin
        buf_q[buf_tail[0]] <= ram.rdata;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shifting_q <= 1'b0;
      bit_cnt_q <= 6'h0;
      shreg_q <= 35'h0;
    end else if (buf_pop) begin
      shifting_q <= 1'b1;
      bit_cnt_q <= 6'(`MON_WORD_CYCLES);
      shreg_q <= {1'b1, buf_q[buf_head_q], 2'h0};
    end else if (shifting_q && tst_tick) begin
      shreg_q <= {shreg_q[33:0], 1'b0};
      bit_cnt_q <= bit_cnt_q - 6'h1;
      if (bit_cnt_q == 6'h1) begin
        shifting_q <= 1'b0;
      end
    end
  end
  assign test_mux_output = shifting_q & shreg_q[34];

  // --------------------------------------------------------------------------
  // Real and reactive pulse FIFO with spacing timer
  // --------------------------------------------------------------------------
  logic [1:0] pfifo_q [0:`PULSE_FIFO_DEPTH-1];
  logic [2:0] pwr_q;
  logic [2:0] prd_q;
  logic [3:0] pcnt_q;
  logic [9:0] space_q;
  wire bypass = (pulse_spacing == 8'h00);
  wire [9:0] space_len = {pulse_spacing, 2'h0};
  wire space_done = fir_tick & (space_q + 10'h1 >= space_len);
  wire fifo_push = pulse_export_valid & pulse_export_ready & ~bypass;
  wire fifo_pop = space_done & (pcnt_q != 4'h0) & ~bypass;
  wire upd = bypass ? pulse_export_valid : fifo_pop;
  wire [1:0] upd_val = bypass ? {reactive_sign, real_sign} : pfifo_q[prd_q];
  assign pulse_export_ready = bypass | (pcnt_q != 4'(`PULSE_FIFO_DEPTH));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_q <= 3'h0;
      prd_q <= 3'h0;
      pcnt_q <= 4'h0;
      space_q <= 10'h0;
    end else if (frame_start) begin
      pwr_q <= 3'h0;
      prd_q <= 3'h0;
      pcnt_q <= 4'h0;
      space_q <= 10'h0;
    end else begin
      if (fifo_push) begin
        pfifo_q[pwr_q] <= {reactive_sign, real_sign};
        pwr_q <= pwr_q + 3'h1;
      end
      if (fifo_pop) begin
        prd_q <= prd_q + 3'h1;
      end
      pcnt_q <= pcnt_q + {3'h0, fifo_push} - {3'h0, fifo_pop};
      if (space_done) begin
        space_q <= 10'h0;
      end else if (fir_tick) begin
        space_q <= space_q + 10'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Width limit per pulse channel
  // --------------------------------------------------------------------------
  logic [1:0] level_q;
  wire [8:0] width_max = {pulse_width_limit, 1'b1};
  wire width_check = (pulse_width_limit != `WIDTH_CHECK_OFF);

  for (genvar ch = 0; ch < 2; ch++) begin : g_width
    logic [8:0] wcnt_q;
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        wcnt_q <= 9'h0;
        level_q[ch] <= 1'b0;
      end else if (upd) begin
        if (!upd_val[ch]) begin
          wcnt_q <= 9'h0;
          level_q[ch] <= 1'b0;
        end else if (width_check && wcnt_q >= width_max) begin
          level_q[ch] <= 1'b0;
        end else begin
          wcnt_q <= wcnt_q + 9'h1;
          level_q[ch] <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Auxiliary pulses and pin drive
  // --------------------------------------------------------------------------
  logic aux_x_q;
  logic aux_y_q;
  logic [4:0] pins_q;
  logic [1:0] opt_level;
  wire pol_off = ~pulse_polarity_invert;
  assign opt_level = (optical_transmit_source == `OPT_SRC_REAL) ? {1'b1, level_q[0]} :
                     (optical_transmit_source == `OPT_SRC_REACTIVE) ? {1'b1, level_q[1]} : 2'h0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_x_q <= 1'b0;
      aux_y_q <= 1'b0;
      pins_q <= 5'h1f;
    end else begin
      if (frame_start) begin
        aux_x_q <= aux_x_level;
        aux_y_q <= aux_y_level;
      end
      pins_q[0] <= level_q[0] ^ pol_off;
      pins_q[1] <= level_q[1] ^ pol_off;
      pins_q[2] <= aux_x_q ^ pol_off;
      pins_q[3] <= aux_y_q ^ pol_off;
      pins_q[4] <= opt_level[1] ? (opt_level[0] ^ pol_off) : 1'b0;
    end
  end
  assign general_io_six = pins_q[0];
  assign general_io_seven = pins_q[1];
  assign general_io_eight = pins_q[2];
  assign general_io_nine = pins_q[3];
  assign optical_transmit = pins_q[4];

endmodule : metering_engine_support

`default_nettype wire

// ### testbench/metering_engine_support_assertions.sv
// Port checker of the metering support block.
`timescale 1ns/100ps
`default_nettype none
`include "metering_map.svh"
module meter_checker (
  input wire logic ref_clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic [15:0] io_addr, // Config address.
  input wire logic [7:0] io_rdata, // Config read data.
  input wire logic monitor_enable, // Monitor enable.
  input wire logic test_mux_output, // Serial monitor bit.
  input wire logic frame_sync, // Frame sync.
  input wire logic alternate_frame, // Alternate frame.
  input wire logic fill_missing_samples, // Fill request.
  input wire logic frame_done_irq, // Frame end.
  input wire logic accumulation_done_irq, // Accumulation end.
  input wire logic mpu_req, // Processor request.
  input wire logic mpu_ack, // Processor done.
  input wire logic spi_ack // Serial done.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_frame_irq_next: assert property ($rose(frame_sync) |=> frame_done_irq) else $error("no frame irq");
  a_frame_irq_single: assert property (frame_done_irq |=> !frame_done_irq) else $error("long frame irq");
  a_acc_on_frame: assert property (accumulation_done_irq |-> frame_done_irq) else $error("lone acc irq");
  a_fill_captured: assert property ($rose(frame_sync) |=> fill_missing_samples == $past(alternate_frame))
    else $error("fill level wrong");
  a_mon_off_low: assert property ($rose(frame_sync) && !monitor_enable |=> !test_mux_output [*8])
    else $error("monitor active while off");
  a_mon_flag_soon: assert property ($rose(frame_sync) && monitor_enable |-> ##[1:16] test_mux_output)
    else $error("no monitor flag");
  a_cfg_unmapped: assert property (io_addr != `ACC_CFG_ADDR |=> io_rdata == 8'h00) else $error("bad read");
  a_mpu_ack_late: assert property (mpu_ack |-> $past(mpu_req, 2)) else $error("ack without request");
  a_spi_one_round: assert property (spi_ack |=> !spi_ack [*4]) else $error("serial ack too soon");
  cover property (accumulation_done_irq);
  cover property (monitor_enable && test_mux_output);
  cover property (mpu_ack);
endmodule : meter_checker
bind metering_engine_support meter_checker chk (.ref_clk, .rst_n, .io_addr, .io_rdata, .monitor_enable,
  .test_mux_output, .frame_sync, .alternate_frame, .fill_missing_samples, .frame_done_irq,
  .accumulation_done_irq, .mpu_req, .mpu_ack, .spi_ack);
`default_nettype wire

// ### testbench/engine_model.sv
// Engine side model: frame sync and wiring equation choice.
`timescale 1ns/100ps
`default_nettype none
module engine_model (
  input wire logic ref_clk, // Clock.
  input wire logic frame_req, // Start a frame.
  output logic frame_sync, // Frame sync.
  output logic [2:0] equation_select // Wiring equation.
);
  logic [2:0] hold_q = 3'h0;
  initial frame_sync = 1'h0;
  initial equation_select = 3'h0;
  always @(posedge ref_clk) begin
    hold_q <= frame_req ? 3'h4 : (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
    frame_sync <= frame_req || hold_q > 3'h1;
    if (frame_req) equation_select <= (equation_select == 3'h5) ? 3'h0 : equation_select + 3'h1;
  end
endmodule : engine_model
`default_nettype wire

// ### testbench/tb_metering_engine_support.sv
// Self-checking bench of the metering support block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t %h %h", $time, a, b); end end
module tb_metering_engine_support;
  logic ref_clk = 1'h0, rst_n = 1'h0, io_we = 1'h0, monitor_enable = 1'h0, alternate_frame = 1'h0, frame_req = 1'h0;
  logic pulse_export_valid = 1'h0, real_sign = 1'h0, reactive_sign = 1'h0, aux_x_level = 1'h0, aux_y_level = 1'h0;
  logic pulse_polarity_invert = 1'h0, mpu_req = 1'h0, mpu_we = 1'h0, ce_req = 1'h0, ce_we = 1'h0;
  logic spi_req = 1'h0, spi_we = 1'h0, frame_sync, test_mux_output, test_clock, fill_missing_samples;
  logic frame_done_irq, accumulation_done_irq, pulse_export_ready, mpu_ack, ce_ack, spi_ack, optical_transmit;
  logic general_io_six, general_io_seven, general_io_eight, general_io_nine;
  logic [7:0] io_wdata = 8'h00, pulse_spacing = 8'h00, mpu_wdata = 8'h00, pulse_width_limit = 8'hff, io_rdata, mpu_rdata;
  logic [15:0] io_addr = 16'h0000;
  logic [39:0] monitor_addr = 40'h0;
  logic [1:0] optical_transmit_source = 2'h1;
  logic [11:0] mpu_addr = 12'h000;
  logic [9:0] ce_addr = 10'h000, spi_addr = 10'h000;
  logic [31:0] ce_wdata = 32'h0, spi_wdata = 32'h0, ce_rdata, spi_rdata;
  logic [2:0] equation_select, equation_assist;
  int err_total = 0, checked = 0, cyc = 0, frm_cnt = 0, acc_cnt = 0;
  metering_engine_support dut (.*);
  engine_model em (.*);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (frame_done_irq === 1'h1) frm_cnt++;
    if (accumulation_done_irq === 1'h1) acc_cnt++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic frame(input int n);
    frame_req = 1'h1;
    tick(1);
    frame_req = 1'h0;
    tick(n);
  endtask : frame
  task automatic ce_write(input logic [9:0] a, input logic [31:0] d);
    int k = 0;
    ce_req = 1'h1; ce_we = 1'h1; ce_addr = a; ce_wdata = d;
    while (ce_ack !== 1'h1 && k < 20) begin tick(1); k++; end
    tick(1); ce_req = 1'h0; ce_we = 1'h0; tick(1);
  endtask : ce_write
  task automatic spi_rw(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    int k = 0;
    spi_req = 1'h1; spi_we = w; spi_addr = a; spi_wdata = d;
    while (spi_ack !== 1'h1 && k < 20) begin tick(1); k++; end
    q = spi_rdata; tick(1); spi_req = 1'h0; tick(1);
  endtask : spi_rw
  task automatic mpu_rw(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int k = 0;
    mpu_req = 1'h1; mpu_we = w; mpu_addr = a; mpu_wdata = d;
    while (mpu_ack !== 1'h1 && k < 20) begin tick(1); k++; end
    q = mpu_rdata; tick(1); mpu_req = 1'h0; tick(1);
  endtask : mpu_rw
  task automatic t_cfg;
    io_addr = 16'h2001; io_wdata = 8'h42; io_we = 1'h1; tick(1); io_we = 1'h0; tick(2);
    `CHK(io_rdata, 8'h42)
    io_addr = 16'h2002; io_wdata = 8'hff; io_we = 1'h1; tick(1); io_we = 1'h0; tick(2);
    `CHK(io_rdata, 8'h00)
  endtask : t_cfg
  task automatic t_acc;
    frm_cnt = 0; acc_cnt = 0; alternate_frame = 1'h1;
    repeat (4) begin frame(30); `CHK(equation_assist, equation_select) end
    `CHK(fill_missing_samples, 1'h1)
    `CHK(frm_cnt, 4)
    `CHK(acc_cnt, 2)
    alternate_frame = 1'h0;
  endtask : t_acc
  task automatic t_mon;
    int k;
    logic [34:0] got;
    ce_write(10'h005, 32'h5a3c_96e1);
    monitor_addr = {4{10'h005}}; monitor_enable = 1'h1; frame_req = 1'h1; tick(1); frame_req = 1'h0;
    k = 0; while (test_mux_output !== 1'h1 && k < 40) begin tick(1); k++; end
    got[34] = test_mux_output;
    k = 0; while (test_mux_output !== 1'h0 && k < 8) begin tick(1); k++; end
    tick(2);
    for (k = 33; k >= 0; k--) begin got[k] = test_mux_output; tick(4); end
    `CHK(got, {1'h1, 32'h5a3c_96e1, 2'h0})
    tick(600);
    `CHK(test_mux_output, 1'h0)
    monitor_enable = 1'h0;
  endtask : t_mon
  task automatic t_pulse;
    for (int i = 0; i < 2; i++) begin
      pulse_polarity_invert = i[0]; real_sign = 1'h1; pulse_export_valid = 1'h1; tick(1); pulse_export_valid = 1'h0; tick(3);
      `CHK(general_io_six, i[0])
      `CHK(general_io_seven, ~i[0])
      `CHK(optical_transmit, i[0])
    end
  endtask : t_pulse
  task automatic t_fifo;
    pulse_spacing = 8'h01; aux_x_level = 1'h1; real_sign = 1'h0; frame_req = 1'h1; tick(1); frame_req = 1'h0;
    tick(1); pulse_export_valid = 1'h1; tick(1); pulse_export_valid = 1'h0; tick(20);
    `CHK(general_io_six, 1'h1)
    tick(40);
    `CHK(general_io_six, 1'h0)
    `CHK(general_io_eight, 1'h1)
    `CHK(general_io_nine, 1'h0)
    pulse_spacing = 8'h08; real_sign = 1'h1; pulse_export_valid = 1'h1; tick(8); pulse_export_valid = 1'h0;
    `CHK(pulse_export_ready, 1'h0)
    tick(90); frame(400);
    `CHK(pulse_export_ready, 1'h1)
    `CHK(general_io_six, 1'h0)
  endtask : t_fifo
  task automatic t_rmw;
    logic [31:0] q;
    logic [7:0] b;
    spi_rw(1'h1, 10'h003, 32'h1122_3344, q); mpu_rw(1'h1, 12'h00d, 8'hab, b); spi_rw(1'h0, 10'h003, 32'h0, q);
    `CHK(q, 32'h1122_ab44)
    mpu_rw(1'h0, 12'h00e, 8'h00, b);
    `CHK(b, 8'h22)
  endtask : t_rmw
  task automatic end_sim;
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    tick(20); rst_n = 1'h1; tick(1);
    t_cfg; t_acc; t_mon; t_pulse; t_fifo; t_rmw;
    end_sim;
  end
endmodule : tb_metering_engine_support
`default_nettype wire
